//--- pkg/kbl_pkg.sv
// Purpose: constants, register map and types of the keyboard link block
// Assumes: 20 MHz system clock, 32-bit Avalon-MM register port
// Notes:   all timing counts are derived here from times in their own unit
`default_nettype none
package kbl_pkg;
    // --------------------------------------------------------------
    // clock and timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int INHIBIT_NS = 60000;
    // least time: round up
    localparam int INHIBIT_CYC =
        (INHIBIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_US = 2000;
    // longest time: round down
    localparam int TIMEOUT_CYC = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int TMR_W = 16;

    // --------------------------------------------------------------
    // register map (byte addresses)
    // --------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_TX = 5'h04;
    localparam logic [4:0] REG_RX = 5'h08;
    localparam logic [4:0] REG_STAT = 5'h0c;
    localparam logic [4:0] REG_OPT = 5'h10;

    // status bits; 2..5 are sticky, write one to clear
    localparam int ST_RXV = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_ACK = 2;
    localparam int ST_NACK = 3;
    localparam int ST_PERR = 4;
    localparam int ST_TO = 5;
    localparam int ST_W = 6;

    // --------------------------------------------------------------
    // link modes and command bytes
    // --------------------------------------------------------------
    localparam logic [1:0] MODE_1 = 2'h1;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] MODE_3 = 2'h3;
    localparam logic [1:0] MODE_RESET = MODE_2;
    localparam logic [7:0] CMD_LEDS = 8'hed;
    localparam logic [7:0] CMD_SCANSET = 8'hf0;
    localparam logic [7:0] CMD_TYPEMATIC = 8'hf3;
    localparam logic [7:0] CMD_RESEND = 8'hfe;
    localparam logic [2:0] LED_MASK = 3'h7;
    localparam logic [6:0] TYPEMATIC_MASK = 7'h7f;
    localparam logic [6:0] TYPEMATIC_RESET = 7'h00;

    // --------------------------------------------------------------
    // frame positions, counted in falling link-clock edges
    // --------------------------------------------------------------
    localparam logic [3:0] BIT_PAR = 4'h8;
    localparam logic [3:0] BIT_STOP = 4'h9;
    localparam logic [3:0] BIT_ACK = 4'ha;
    localparam logic [3:0] RX_LAST = 4'ha;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_WAITRX = 5'h02,
        TX_INHIBIT = 5'h04,
        TX_SEND = 5'h08,
        TX_HOLD = 5'h10
    } kbl_tx_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } kbl_avl_req_t;
endpackage
`default_nettype wire

//--- src/kbl_link.sv
// Purpose: host-side serial link controller with Avalon-MM registers
// Assumes: keyboard makes every link clock; pins are open drain
// Notes:   one retry after a failed transmit of a REG_TX byte; received errors ask resend in modes 2 and 3 with the transmitter idle
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`default_nettype none
module kbl_link
    import kbl_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire kbl_pkg::kbl_avl_req_t avl_req,
    output logic [31:0] avl_readdata,
    output logic avl_waitrequest,
    input wire logic kbd_clk_in,
    output logic kbd_clk_out,
    output logic kbd_clk_oe,
    input wire logic kbd_data_in,
    output logic kbd_data_out,
    output logic kbd_data_oe,
    output logic keyboard_irq_line
);
    if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES >= (1 << TMR_W)) begin : g_to_chk
        $error("TIMEOUT_CYCLES out of range");
    end
    if (INHIBIT_CYC >= (1 << TMR_W)) begin : g_inh_chk
        $error("inhibit count too wide");
    end

    localparam logic [TMR_W-1:0] INH_LAST = TMR_W'(INHIBIT_CYC - 1);
    localparam logic [TMR_W-1:0] TO_LAST = TMR_W'(TIMEOUT_CYCLES - 1);

    // --------------------------------------------------------------
    // pin synchronisers and edge detect
    // --------------------------------------------------------------
    logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2;
    logic fall;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            clk_s1 <= 1'b1;
            clk_s2 <= 1'b1;
            clk_s3 <= 1'b1;
            dat_s1 <= 1'b1;
            dat_s2 <= 1'b1;
        end else begin
            clk_s1 <= kbd_clk_in;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            dat_s1 <= kbd_data_in;
            dat_s2 <= dat_s1;
        end
    end
    assign fall = clk_s3 & ~clk_s2;

    // --------------------------------------------------------------
    // bus slave
    // --------------------------------------------------------------
    logic req, take, take_wr, take_rd;
    logic [1:0] mode;
    logic [2:0] leds;
    logic [6:0] typematic;
    logic [7:0] rx_byte, last_sw;
    logic [ST_W-1:0] stat;
    kbl_tx_state_t tx_state;

    assign req = avl_req.read | avl_req.write;
    assign take = req & ~avl_waitrequest;
    assign take_wr = take & avl_req.write & avl_req.byteenable[0];
    assign take_rd = take & avl_req.read;

    // answer one cycle after the request appears, for one cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            avl_waitrequest <= 1'b1;
            avl_readdata <= 32'h0;
        end else begin
            avl_waitrequest <= ~(req & avl_waitrequest);
            if (avl_req.read && avl_waitrequest) begin
                if (avl_req.address == REG_CTRL) begin
                    avl_readdata <= {30'h0, mode};
                end else if (avl_req.address == REG_RX) begin
                    avl_readdata <= {24'h0, rx_byte};
                end else if (avl_req.address == REG_STAT) begin
                    avl_readdata <= {{(32 - ST_W){1'b0}}, stat};
                end else if (avl_req.address == REG_OPT) begin
                    avl_readdata <= {12'h0, mode, leds, typematic, last_sw};
                end else begin
                    avl_readdata <= 32'h0;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // receive path
    // --------------------------------------------------------------
    logic [3:0] rx_cnt;
    logic [9:0] rx_sh;
    logic [TMR_W-1:0] rx_tmr;
    logic rx_done, rx_perr, rx_to;
    logic rx_en;

    // the receiver only listens while the transmitter leaves the pins alone
    assign rx_en = (tx_state == TX_IDLE) || (tx_state == TX_WAITRX);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rx_cnt <= 4'h0;
            rx_sh <= 10'h0;
            rx_tmr <= '0;
            rx_done <= 1'b0;
            rx_perr <= 1'b0;
            rx_to <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            rx_perr <= 1'b0;
            rx_to <= 1'b0;
            if (!rx_en) begin
                rx_cnt <= 4'h0;
                rx_tmr <= '0;
            end else if (fall) begin
                rx_tmr <= '0;
                if (rx_cnt == 4'h0) begin
                    // a high start bit is a glitch, not a frame
                    rx_cnt <= dat_s2 ? 4'h0 : 4'h1;
                end else if (rx_cnt == RX_LAST) begin
                    rx_cnt <= 4'h0;
                    if (^rx_sh[9:1]) begin
                        rx_done <= 1'b1;
                    end else begin
                        rx_perr <= 1'b1;
                    end
                end else begin
                    rx_sh <= {dat_s2, rx_sh[9:1]};
                    rx_cnt <= rx_cnt + 4'h1;
                end
            end else if (rx_cnt != 4'h0) begin
                if (rx_tmr == TO_LAST) begin
                    rx_cnt <= 4'h0;
                    rx_to <= 1'b1;
                end else begin
                    rx_tmr <= rx_tmr + 1'b1;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // transmit path
    // --------------------------------------------------------------
    logic [7:0] tx_byte;
    logic [3:0] tx_cnt;
    logic [TMR_W-1:0] tx_tmr;
    logic tx_pend, tx_retried, tx_ok, tx_bad, tx_to, sw_tx, bidir;

    assign bidir = (mode != MODE_1);
    assign sw_tx = take_wr && avl_req.address == REG_TX && bidir
        && tx_state == TX_IDLE && !tx_pend;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tx_state <= TX_IDLE;
            tx_byte <= 8'h0;
            tx_cnt <= 4'h0;
            tx_tmr <= '0;
            tx_pend <= 1'b0;
            tx_retried <= 1'b0;
            tx_ok <= 1'b0;
            tx_bad <= 1'b0;
            tx_to <= 1'b0;
            kbd_clk_oe <= 1'b0;
            kbd_data_oe <= 1'b0;
        end else begin
            tx_ok <= 1'b0;
            tx_bad <= 1'b0;
            tx_to <= 1'b0;
            if (sw_tx) begin
                tx_byte <= avl_req.writedata[7:0];
                tx_pend <= 1'b1;
                tx_retried <= 1'b0;
            end else if (tx_state == TX_IDLE && !tx_pend && bidir
                    && (rx_perr || rx_to)) begin
                tx_byte <= CMD_RESEND;
                tx_pend <= 1'b1;
                tx_retried <= 1'b1;
            end else if (tx_state == TX_IDLE && !tx_pend && bidir
                    && rx_done && rx_sh[8:1] == CMD_RESEND) begin
                tx_pend <= 1'b1; // keyboard asked again
                tx_retried <= 1'b1;
            end
            case (tx_state)
                TX_IDLE: begin
                    if (tx_pend) begin
                        tx_state <= TX_WAITRX;
                    end
                end
                TX_WAITRX: begin
                    if (rx_cnt == 4'h0 && !fall) begin
                        kbd_clk_oe <= 1'b1;
                        tx_tmr <= '0;
                        tx_state <= TX_INHIBIT;
                    end
                end
                TX_INHIBIT: begin
                    if (tx_tmr == INH_LAST) begin
                        kbd_data_oe <= 1'b1;
                        kbd_clk_oe <= 1'b0;
                        tx_cnt <= 4'h0;
                        tx_tmr <= '0;
                        tx_state <= TX_SEND;
                    end else begin
                        tx_tmr <= tx_tmr + 1'b1;
                    end
                end
                TX_SEND: begin
                    if (fall) begin
                        tx_tmr <= '0;
                        tx_cnt <= tx_cnt + 4'h1;
                        if (tx_cnt < BIT_PAR) begin
                            kbd_data_oe <= ~tx_byte[tx_cnt[2:0]];
                        end else if (tx_cnt == BIT_PAR) begin
                            kbd_data_oe <= ^tx_byte;
                        end else if (tx_cnt == BIT_STOP) begin
                            kbd_data_oe <= 1'b0;
                        end else begin
                            // line acknowledge is a low data level
                            tx_ok <= ~dat_s2;
                            tx_bad <= dat_s2;
                            tx_pend <= dat_s2 & ~tx_retried;
                            tx_retried <= 1'b1;
                            kbd_clk_oe <= 1'b1;
                            tx_state <= TX_HOLD;
                        end
                    end else if (tx_tmr == TO_LAST) begin
                        kbd_data_oe <= 1'b0;
                        tx_to <= 1'b1;
                        tx_pend <= ~tx_retried;
                        tx_retried <= 1'b1;
                        tx_state <= TX_IDLE;
                    end else begin
                        tx_tmr <= tx_tmr + 1'b1;
                    end
                end
                TX_HOLD: begin
                    if (tx_tmr == INH_LAST) begin
                        kbd_clk_oe <= 1'b0;
                        tx_state <= TX_IDLE;
                    end else begin
                        tx_tmr <= tx_tmr + 1'b1;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
            if (tx_state == TX_SEND && (fall && tx_cnt == BIT_ACK
                    || !fall && tx_tmr == TO_LAST) && !tx_retried) begin
                tx_pend <= tx_pend;
            end else if (tx_state == TX_HOLD && tx_tmr == INH_LAST) begin
                tx_pend <= tx_pend;
            end
            if (tx_state == TX_SEND && fall && tx_cnt == BIT_ACK
                    && !dat_s2) begin
                tx_pend <= 1'b0;
            end
        end
    end

    // pins only ever pull low
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            kbd_clk_out <= 1'b0;
            kbd_data_out <= 1'b0;
        end else begin
            kbd_clk_out <= 1'b0;
            kbd_data_out <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // mode and option byte tracking
    // --------------------------------------------------------------
    logic scan_ok;
    assign scan_ok = avl_req.writedata[7:2] == 6'h0
        && avl_req.writedata[1:0] != 2'h0;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode <= MODE_RESET;
            leds <= 3'h0;
            typematic <= TYPEMATIC_RESET;
            last_sw <= 8'h0;
        end else begin
            if (sw_tx) begin
                last_sw <= avl_req.writedata[7:0];
                if (last_sw == CMD_LEDS) begin
                    leds <= avl_req.writedata[2:0] & LED_MASK;
                end
                if (last_sw == CMD_TYPEMATIC) begin
                    typematic <= avl_req.writedata[6:0]
                        & TYPEMATIC_MASK;
                end
                if (last_sw == CMD_SCANSET && scan_ok) begin
                    mode <= avl_req.writedata[1:0];
                end
            end else if (take_wr && avl_req.address == REG_CTRL
                    && avl_req.writedata[1:0] != 2'h0) begin
                mode <= avl_req.writedata[1:0];
            end
        end
    end

    // --------------------------------------------------------------
    // status, received byte and interrupt line
    // --------------------------------------------------------------
    logic clr_wr, rx_rd;
    assign clr_wr = take_wr && avl_req.address == REG_STAT;
    assign rx_rd = take_rd && avl_req.address == REG_RX;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stat <= '0;
            rx_byte <= 8'h0;
            keyboard_irq_line <= 1'b0;
        end else begin
            if (rx_done) begin
                rx_byte <= rx_sh[8:1];
            end
            // a new event beats a clear in the same cycle
            stat[ST_RXV] <= rx_done | (stat[ST_RXV] & ~rx_rd);
            stat[ST_BUSY] <= tx_pend | (tx_state != TX_IDLE);
            stat[ST_ACK] <= tx_ok
                | (stat[ST_ACK] & ~(clr_wr & avl_req.writedata[ST_ACK]));
            stat[ST_NACK] <= tx_bad
                | (stat[ST_NACK] & ~(clr_wr & avl_req.writedata[ST_NACK]));
            stat[ST_PERR] <= rx_perr
                | (stat[ST_PERR] & ~(clr_wr & avl_req.writedata[ST_PERR]));
            stat[ST_TO] <= rx_to | tx_to
                | (stat[ST_TO] & ~(clr_wr & avl_req.writedata[ST_TO]));
            keyboard_irq_line <= rx_done | (stat[ST_RXV] & ~rx_rd);
        end
    end
endmodule
`default_nettype wire

//--- test/kbl_link_properties.sv
// Purpose: bus handshake and link pin checks for kbl_link
// Assumes: registered outputs, one clk_sys domain
// Notes:   bound to every kbl_link instance
`default_nettype none
module kbl_link_chk
    import kbl_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire kbl_pkg::kbl_avl_req_t avl_req,
    input wire logic [31:0] avl_readdata,
    input wire logic avl_waitrequest,
    input wire logic kbd_clk_in,
    input wire logic kbd_clk_out,
    input wire logic kbd_clk_oe,
    input wire logic kbd_data_in,
    input wire logic kbd_data_out,
    input wire logic kbd_data_oe,
    input wire logic keyboard_irq_line
);
    logic [15:0] clamp_cnt;
    logic req, zero_rd, rx_rd;
    assign req = avl_req.read | avl_req.write;
    assign zero_rd = avl_req.read
        & (avl_req.address == REG_TX || avl_req.address > REG_OPT);
    assign rx_rd = avl_req.read & (avl_req.address == REG_RX);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // ----------------------------------------------------------
    // clamp length counter
    // ----------------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset)
            clamp_cnt <= 16'h0;
        else if (!kbd_clk_oe)
            clamp_cnt <= 16'h0;
        else if (clamp_cnt != 16'hffff)
            clamp_cnt <= clamp_cnt + 16'h1;
    end
    property p_wait_one;
        req && avl_waitrequest |=> !avl_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer");
    property p_wait_pulse;
        !avl_waitrequest |=> avl_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("held");
    property p_wait_idle;
        !req |-> avl_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("stray");
    property p_read_zero;
        zero_rd && !avl_waitrequest |-> avl_readdata == 32'h0;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("nonzero");
    property p_irq_clear;
        rx_rd && !avl_waitrequest |=> !keyboard_irq_line;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq");
    property p_pins_low;
        !kbd_clk_out && !kbd_data_out;
    endproperty
    a_pins_low: assert property (p_pins_low) else $error("pin high");
    property p_inhibit;
        $fell(kbd_clk_oe) |-> clamp_cnt >= INHIBIT_CYC;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("short");
    property p_clamp_max;
        kbd_clk_oe |-> clamp_cnt <= INHIBIT_CYC + 2;
    endproperty
    a_clamp_max: assert property (p_clamp_max) else $error("long");
    property p_one_driver;
        !(kbd_clk_oe && kbd_data_oe);
    endproperty
    a_one_driver: assert property (p_one_driver) else $error("both");
    property p_start;
        $fell(kbd_clk_oe) && kbd_data_oe |=> kbd_data_oe [*3];
    endproperty
    a_start: assert property (p_start) else $error("start");
endmodule
bind kbl_link kbl_link_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
    .clk_sys(clk_sys), .reset(reset), .avl_req(avl_req),
    .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest),
    .kbd_clk_in(kbd_clk_in), .kbd_clk_out(kbd_clk_out),
    .kbd_clk_oe(kbd_clk_oe), .kbd_data_in(kbd_data_in),
    .kbd_data_out(kbd_data_out), .kbd_data_oe(kbd_data_oe),
    .keyboard_irq_line(keyboard_irq_line));
`default_nettype wire

//--- test/kbl_kbd_model.sv
// Purpose: behavioural keyboard on the far side of the link
// Assumes: open-drain lines with pull-ups, 400 ns link clock
// Notes:   clock runs only inside frames
`default_nettype none
module kbl_kbd_model #(
    parameter logic [7:0] ACK_CODE = 8'hfa,
    parameter logic [15:0] ID_WORD = 16'h5a3c // arbitrary
) (
    input wire logic clk_line,
    input wire logic data_line,
    output logic clk_low,
    output logic data_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ack_en = 1'b1;
    logic reply_en = 1'b0;
    logic [10:0] got = 11'h0;
    int rx_cnt = 0;
    initial begin
        clk_low = 1'b0;
        data_low = 1'b0;
    end
    task automatic send(input logic [7:0] b, input logic bad_par);
        logic [10:0] f;
        f = {1'b1, ~^b ^ bad_par, b, 1'b0};
        wait (clk_line === 1'b1);
        for (int i = 0; i < 11; i++) begin
            data_low = ~f[i];
            #110 clk_low = 1'b1;
            #200 clk_low = 1'b0;
            #90;
        end
        data_low = 1'b0;
    endtask
    // ----------------------------------------------------------
    // host frame
    // ----------------------------------------------------------
    always @(negedge data_line) begin
        if (!data_low) begin
            wait (clk_line === 1'b1);
            for (int i = 0; i < 11; i++) begin
                #60 clk_low = 1'b1;
                #200 clk_low = 1'b0;
                #130 got[i] = data_line;
                if (i == 9)
                    data_low = ack_en;
                #10;
            end
            data_low = 1'b0;
            rx_cnt++;
            if (reply_en && got[7:0] != 8'hef && got[7:0] != 8'hf1) begin
                #1000;
                send(got[7:0] == 8'hee ? 8'hee : ACK_CODE, 1'b0);
                for (int k = 0; k < 2 && got[7:0] == 8'hf2; k++)
                    send(ID_WORD[8*k+:8], 1'b0);
            end
        end
    end
endmodule
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench for kbl_link with a keyboard model
// Assumes: 20 MHz clk_sys, short link timeout
// Notes:   byte table first, link faults and reset by hand after
`default_nettype none
module tb
    import kbl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] b; logic p;} kbl_row_t;
    kbl_row_t rows [10] = '{'{8'h00, 1'b1}, '{8'hff, 1'b1}, '{8'hed, 1'b1},
        '{8'h05, 1'b1}, '{8'hf3, 1'b1}, '{8'h6b, 1'b0}, '{8'hf0, 1'b1},
        '{8'h03, 1'b1}, '{8'hf0, 1'b1}, '{8'h02, 1'b0}};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    kbl_avl_req_t avl_req = '0;
    logic [31:0] avl_readdata;
    logic avl_waitrequest, kbd_clk_out, kbd_clk_oe, kbd_data_out;
    logic kbd_data_oe, keyboard_irq_line, kbd_clk_low, kbd_data_low;
    wire logic clk_line = ~(kbd_clk_oe | kbd_clk_low);
    wire logic data_line = ~(kbd_data_oe | kbd_data_low);
    int n_mismatch = 0;
    int n_compared = 0;
    always #25 clk_sys = ~clk_sys;
    kbl_link #(.TIMEOUT_CYCLES(200)) DUT (.clk_sys(clk_sys), .reset(reset),
        .avl_req(avl_req), .avl_readdata(avl_readdata),
        .avl_waitrequest(avl_waitrequest), .kbd_clk_in(clk_line),
        .kbd_clk_out(kbd_clk_out), .kbd_clk_oe(kbd_clk_oe),
        .kbd_data_in(data_line), .kbd_data_out(kbd_data_out),
        .kbd_data_oe(kbd_data_oe), .keyboard_irq_line(keyboard_irq_line));
    kbl_kbd_model mdl (.clk_line(clk_line), .data_line(data_line),
        .clk_low(kbd_clk_low), .data_low(kbd_data_low));
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic fail(input string what);
        n_mismatch++;
        $display("unexpected wait on %s: expected done seen hang", what);
        close_out();
    endtask
    task automatic chk32(input string what, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk8(input string what, input logic [7:0] e,
        input logic [7:0] g);
        chk32(what, {24'h0, e}, {24'h0, g});
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        chk32(what, {31'h0, e}, {31'h0, g});
    endtask
    // ----------------------------------------------------------
    // bus master: hold until waitrequest is sampled low
    // ----------------------------------------------------------
    task automatic bus(input logic rd, input logic [4:0] a,
        input logic [31:0] wd, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        avl_req.read <= rd;
        avl_req.write <= ~rd;
        avl_req.address <= a;
        avl_req.writedata <= wd;
        avl_req.byteenable <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avl_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            fail("bus");
        q = avl_readdata;
        avl_req.read <= 1'b0;
        avl_req.write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(1'b1, a, 32'h0, q);
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            rd(REG_STAT, s);
            n++;
        end while (s[ST_BUSY] !== 1'b0 && n < 5000);
        if (n >= 5000)
            fail("busy");
    endtask
    task automatic wait_kbd(input int c);
        int n;
        for (n = 0; n < 20000 && mdl.rx_cnt < c; n++)
            @(posedge clk_sys);
        if (n >= 20000)
            fail("kbd frame");
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 2000 && keyboard_irq_line !== 1'b1; n++)
            @(posedge clk_sys);
        if (n >= 2000)
            fail("irq");
    endtask
    initial begin
        logic [31:0] q;
        logic [7:0] prev, b;
        logic [2:0] leds;
        logic [6:0] typ;
        logic [1:0] mode;
        int c;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rd(REG_CTRL, q);
        chk32("mode", 32'h2, q);
        rd(REG_OPT, q);
        chk32("options", 32'h0008_0000, q);
        rd(REG_STAT, q);
        chk32("status", 32'h0, q);
        rd(5'h14, q);
        chk32("unmapped", 32'h0, q);
        prev = 8'h00;
        leds = 3'h0;
        typ = 7'h00;
        mode = 2'h2;
        foreach (rows[i]) begin
            b = rows[i].b;
            wr(REG_TX, {24'h0, b});
            wait_kbd(i + 1);
            wait_idle();
            chk8("data bits", b, mdl.got[7:0]);
            chk1("parity", rows[i].p, mdl.got[8]);
            chk1("stop", 1'b1, mdl.got[9]);
            rd(REG_STAT, q);
            chk1("ack seen", 1'b1, q[ST_ACK]);
            wr(REG_STAT, 32'h3c);
            if (prev == 8'hed)
                leds = b[2:0];
            if (prev == 8'hf3)
                typ = b[6:0];
            if (prev == 8'hf0 && b >= 8'h01 && b <= 8'h03)
                mode = b[1:0];
            prev = b;
            rd(REG_OPT, q);
            chk32("opt", {12'h0, mode, leds, typ, b}, q);
        end
        c = mdl.rx_cnt;
        wr(REG_CTRL, 32'h0);
        rd(REG_CTRL, q);
        chk32("mode", 32'h2, q);
        wr(REG_CTRL, 32'h1);
        wr(REG_TX, 32'h55);
        repeat (3000) @(posedge clk_sys);
        chk32("mode 1 frames", c, mdl.rx_cnt);
        wr(REG_CTRL, 32'h2);
        mdl.ack_en = 1'b0;
        wr(REG_TX, 32'hef);
        wait_kbd(c + 2);
        wait_idle();
        mdl.ack_en = 1'b1;
        rd(REG_STAT, q);
        chk1("no ack", 1'b1, q[ST_NACK]);
        wr(REG_STAT, 32'h3c);
        mdl.send(8'h5a, 1'b0);
        wait_irq();
        rd(REG_RX, q);
        chk32("rx byte", 32'h5a, q);
        @(posedge clk_sys);
        chk1("irq", 1'b0, keyboard_irq_line);
        c = mdl.rx_cnt;
        fork
            mdl.send(8'h3c, 1'b0);
            #2000 wr(REG_TX, 32'ha5);
        join
        wait_kbd(c + 1);
        wait_idle();
        chk8("tx after rx", 8'ha5, mdl.got[7:0]);
        rd(REG_RX, q);
        chk32("rx byte", 32'h3c, q);
        mdl.send(8'h81, 1'b1);
        wait_kbd(c + 2);
        wait_idle();
        chk8("resend code", 8'hfe, mdl.got[7:0]);
        rd(REG_STAT, q);
        chk1("parity error", 1'b1, q[ST_PERR]);
        wr(REG_STAT, 32'h3c);
        wr(REG_TX, 32'h96);
        wait_kbd(c + 3);
        wait_idle();
        mdl.send(8'hfe, 1'b0);
        wait_kbd(c + 4);
        wait_idle();
        chk8("resent byte", 8'h96, mdl.got[7:0]);
        mdl.reply_en = 1'b1;
        rd(REG_RX, q);
        wr(REG_TX, 32'hee);
        wait_kbd(c + 5);
        wait_irq();
        rd(REG_RX, q);
        chk32("echo", 32'hee, q);
        wr(REG_CTRL, 32'h3);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd(REG_CTRL, q);
        chk32("mode after reset", 32'h2, q);
        close_out();
    end
endmodule
`default_nettype wire
